//--- pkg/pocr_pkg.sv
package pocr_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam int NREG = 14;

  localparam int IDX_TRIM     = 0;
  localparam int IDX_CEIL     = 1;
  localparam int IDX_MHI      = 2;
  localparam int IDX_MLO      = 3;
  localparam int IDX_SLEW     = 4;
  localparam int IDX_RATIO    = 5;
  localparam int IDX_FSW      = 6;
  localparam int IDX_INPUT_TURN_ON_LEVEL   = 7;
  localparam int IDX_INPUT_TURN_OFF_LEVEL  = 8;
  localparam int IDX_ROLE     = 9;
  localparam int IDX_OV_TRIP  = 10;
  localparam int IDX_OV_REACT = 11;
  localparam int IDX_OV_ALERT = 12;
  localparam int IDX_UV_ALERT = 13;

  // command codes, same order as the indices
  localparam logic [7:0] REG_CODE [NREG] = '{
    8'h22, 8'h24, 8'h25, 8'h26, 8'h27, 8'h29, 8'h33,
    8'h35, 8'h36, 8'h37, 8'h40, 8'h41, 8'h42, 8'h43};

  // stored defaults; the trim entry is replaced by the factory value
  localparam logic [15:0] REG_RST [NREG] = '{
    16'h0000, 16'h1c00, 16'h0142, 16'h0123, 16'he002, 16'he808, 16'h0258,
    16'hf814, 16'hf812, 16'h0100, 16'h0161, 16'h00f8, 16'h0151, 16'h0114};

  // writable bits of each register
  localparam logic [15:0] REG_MASK [NREG] = '{
    16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff,
    16'hffff, 16'hffff, 16'h0ff0, 16'hffff, 16'h00ff, 16'hffff, 16'hffff};

  // ****************************************
  // fixed values and field limits
  // ****************************************
  localparam logic [7:0]  MODE_CODE     = 8'h20;
  localparam logic [15:0] MODE_VALUE    = 16'h0017;
  localparam logic [15:0] TRIM_MIN      = 16'hfc00;
  localparam logic [15:0] TRIM_MAX      = 16'h0400;
  localparam logic [15:0] RATIO_ONE     = 16'he808;
  localparam logic [15:0] RATIO_HALF    = 16'he804;
  localparam logic [15:0] RATIO_QUARTER = 16'he802;
  localparam logic [15:0] RATIO_EIGHTH  = 16'he801;
  localparam logic [7:0]  OV_REACT_HOLD = 8'hf8;
  localparam logic [7:0]  OV_REACT_NONE = 8'h00;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic        write;
    logic [7:0]  code;
    logic [15:0] wdata;
  } pocr_cmd_s;

  typedef struct packed {
    logic        ack;
    logic        err;
    logic [15:0] rdata;
  } pocr_rsp_s;

  typedef struct packed {
    logic [15:0] trim;
    logic [15:0] ceil;
    logic [15:0] margin_hi;
    logic [15:0] margin_lo;
    logic [15:0] slew;
    logic [15:0] ratio;
    logic [15:0] fsw;
    logic [15:0] input_turn_on_level;
    logic [15:0] input_turn_off_level;
    logic [15:0] role;
    logic [15:0] ov_trip;
    logic [7:0]  ov_react;
    logic [15:0] ov_alert;
    logic [15:0] uv_alert;
  } pocr_cfg_s;

  typedef enum logic [1:0] {
    ST_OFF   = 2'b00,
    ST_RUN   = 2'b01,
    ST_HOLD  = 2'b11,
    ST_LATCH = 2'b10
  } pocr_state_e;

endpackage

//--- src/pocr_reg_cell.sv
`timescale 1ns/1ns
module pocr_reg_cell
  import pocr_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic [15:0] rst_val_in,
  input  wire logic [15:0] mask_in,
  input  wire logic        we_in,
  input  wire logic [15:0] wdata_in,
  output logic      [15:0] q_out
);

  logic [15:0] val_d;
  logic [15:0] val_q;

  // next value: default on reset, masked data on write
  always_comb begin
    val_d = val_q;
    if (rst_in) begin
      val_d = rst_val_in & mask_in;
    end else if (we_in) begin
      val_d = wdata_in & mask_in;
    end
  end

  // storage
  always_ff @(posedge clk_in) begin
    val_q <= val_d;
  end

  assign q_out = val_q;

endmodule // pocr_reg_cell

//--- src/pocr_ov_ctrl.sv
`timescale 1ns/1ns
module pocr_ov_ctrl
  import pocr_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic [7:0] react_in,
  input  wire logic       ov_fault_in,
  input  wire logic       ctrl_pin_in,
  input  wire logic       op_on_in,
  input  wire logic       bias_ok_in,
  input  wire logic       other_fault_in,
  output logic            output_en_out,
  output logic            ov_hold_out
);

  pocr_state_e st_d;
  pocr_state_e st_q;
  logic        on_ok;

  // either off source stops the unit
  assign on_ok = ctrl_pin_in && op_on_in && bias_ok_in && !other_fault_in;

  // ****************************************
  // output state machine
  // ****************************************
  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_OFF: begin
        if (on_ok) begin
          st_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!on_ok) begin
          st_d = ST_OFF;
        end else if (ov_fault_in && react_in == OV_REACT_HOLD) begin
          st_d = ST_HOLD;
        end else if (ov_fault_in && react_in != OV_REACT_NONE) begin
          st_d = ST_LATCH;
        end
      end
      ST_HOLD: begin
        if (!on_ok) begin
          st_d = ST_OFF;
        end else if (!ov_fault_in) begin
          st_d = ST_RUN;
        end
      end
      ST_LATCH: begin
        if (!on_ok) begin
          st_d = ST_OFF;
        end
      end
      default: st_d = ST_OFF;
    endcase
  end

  // state register
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_q <= ST_OFF;
    end else begin
      st_q <= st_d;
    end
  end

  assign output_en_out = (st_q == ST_RUN);
  assign ov_hold_out   = (st_q == ST_HOLD);

  // ****************************************
  // checks
  // ****************************************
  property p_ov_disables;
    @(posedge clk_in) disable iff (rst_in)
    (output_en_out && ov_fault_in && react_in == OV_REACT_HOLD) |=> !output_en_out;
  endproperty
  a_ov_disables: assert property (p_ov_disables)
    else $error("output stayed on during over-voltage");

  property p_resume;
    @(posedge clk_in) disable iff (rst_in)
    (ov_hold_out && !ov_fault_in && on_ok) |=> output_en_out;
  endproperty
  a_resume: assert property (p_resume)
    else $error("output did not resume after over-voltage cleared");

  property p_unlimited;
    @(posedge clk_in) disable iff (rst_in)
    (ov_hold_out && on_ok) [*3] |-> ##1 (ov_hold_out || output_en_out);
  endproperty
  a_unlimited: assert property (p_unlimited)
    else $error("retries stopped without an off cause");

  property p_off_sources;
    @(posedge clk_in) disable iff (rst_in)
    (!ctrl_pin_in || !op_on_in) |=> !output_en_out && !ov_hold_out;
  endproperty
  a_off_sources: assert property (p_off_sources)
    else $error("off command not honoured");

endmodule // pocr_ov_ctrl

//--- src/pocr_regs.sv
`timescale 1ns/1ns
// Notes on behaviour
// - trim powers up with the factory value; signed offsets about 2 mV per step.
// - default over-voltage reaction keeps output off while the fault lasts.
// - default reaction turns output back on once the fault clears.
// - default reaction retries forever until off, bias loss or other fault.
// - off from the control pin or the operation command, either, stops retries.
// - role word bits 11:8 pick master/slave, default 0001; 15:12 and 3:0 unused.
// - role bits 7:4 default 0000, meaning master.
// - loop ratio defaults to one; only 1/8, 1/4, 1/2 and 1 accepted.
// - output registers are LINEAR16, mode register reads exponent -9.
// - faults while a margin is selected follow the fault reactions.
module pocr_regs
  import pocr_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        cmd_valid_in,
  input  wire pocr_cmd_s   cmd_in,
  input  wire logic [15:0] factory_trim_in,
  input  wire logic        ov_fault_in,
  input  wire logic        margin_sel_in,
  input  wire logic        ctrl_pin_in,
  input  wire logic        op_on_in,
  input  wire logic        bias_ok_in,
  input  wire logic        other_fault_in,
  output pocr_rsp_s        rsp_out,
  output pocr_cfg_s        cfg_out,
  output logic             output_en_out,
  output logic             ov_hold_out
);

  logic [15:0] reg_val [NREG];
  logic [NREG-1:0] we;
  logic [NREG-1:0] hit;
  logic [3:0]  idx;
  logic        any_hit;
  logic        data_ok;
  logic [15:0] rd_sel;
  pocr_rsp_s   rsp_d;
  pocr_rsp_s   rsp_q;

  // ****************************************
  // address decode
  // ****************************************
  // one-hot match of the command code against the table
  always_comb begin
    hit     = '0;
    idx     = 4'h0;
    any_hit = 1'b0;
    for (int i = 0; i < NREG; i++) begin
      if (cmd_in.code == REG_CODE[i]) begin
        hit[i]  = 1'b1;
        idx     = 4'(i);
        any_hit = 1'b1;
      end
    end
  end

  // ****************************************
  // value checks on write
  // ****************************************
  // reject values outside the accepted set
  always_comb begin
    data_ok = 1'b1;
    if (hit[IDX_RATIO]) begin
      data_ok = (cmd_in.wdata == RATIO_ONE)     ||
                (cmd_in.wdata == RATIO_HALF)    ||
                (cmd_in.wdata == RATIO_QUARTER) ||
                (cmd_in.wdata == RATIO_EIGHTH);
    end else if (hit[IDX_TRIM]) begin
      data_ok = ($signed(cmd_in.wdata) >= $signed(TRIM_MIN)) &&
                ($signed(cmd_in.wdata) <= $signed(TRIM_MAX));
    end else if (hit[IDX_OV_REACT]) begin
      case (cmd_in.wdata)
        16'h0000, 16'h0016, 16'h0022, 16'h0036, 16'h00c0,
        16'h00d6, 16'h00e2, 16'h00f6, 16'h00f8: data_ok = 1'b1;
        default: data_ok = 1'b0;
      endcase
    end
  end

  // ****************************************
  // command handling
  // ****************************************
  // write strobes and the registered answer
  always_comb begin
    we     = '0;
    rd_sel = reg_val[idx];
    rsp_d  = '0;
    if (cmd_valid_in) begin
      rsp_d.ack = 1'b1;
      if (cmd_in.code == MODE_CODE) begin
        rsp_d.err   = cmd_in.write;
        rsp_d.rdata = cmd_in.write ? 16'h0000 : MODE_VALUE;
      end else if (!any_hit) begin
        rsp_d.err = 1'b1;
      end else if (cmd_in.write) begin
        if (data_ok) begin
          we = hit;
        end else begin
          rsp_d.err = 1'b1;
        end
      end else begin
        rsp_d.rdata = rd_sel;
      end
    end
  end

  // answer register
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rsp_q <= '0;
    end else begin
      rsp_q <= rsp_d;
    end
  end

  assign rsp_out = rsp_q;

  // ****************************************
  // register storage
  // ****************************************
  // trim takes the factory value, the rest their stored default
  for (genvar g = 0; g < NREG; g++) begin : g_reg
    pocr_reg_cell u_cell (
      .clk_in     (clk_in),
      .rst_in     (rst_in),
      .rst_val_in ((g == IDX_TRIM) ? factory_trim_in : REG_RST[g]),
      .mask_in    (REG_MASK[g]),
      .we_in      (we[g]),
      .wdata_in   (cmd_in.wdata),
      .q_out      (reg_val[g])
    );
  end

  // configuration seen by the regulator
  assign cfg_out.trim      = reg_val[IDX_TRIM];
  assign cfg_out.ceil      = reg_val[IDX_CEIL];
  assign cfg_out.margin_hi = reg_val[IDX_MHI];
  assign cfg_out.margin_lo = reg_val[IDX_MLO];
  assign cfg_out.slew      = reg_val[IDX_SLEW];
  assign cfg_out.ratio     = reg_val[IDX_RATIO];
  assign cfg_out.fsw       = reg_val[IDX_FSW];
  assign cfg_out.input_turn_on_level    = reg_val[IDX_INPUT_TURN_ON_LEVEL];
  assign cfg_out.input_turn_off_level   = reg_val[IDX_INPUT_TURN_OFF_LEVEL];
  assign cfg_out.role      = reg_val[IDX_ROLE];
  assign cfg_out.ov_trip   = reg_val[IDX_OV_TRIP];
  assign cfg_out.ov_react  = reg_val[IDX_OV_REACT][7:0];
  assign cfg_out.ov_alert  = reg_val[IDX_OV_ALERT];
  assign cfg_out.uv_alert  = reg_val[IDX_UV_ALERT];

  // ****************************************
  // over-voltage reaction
  // ****************************************
  // margin selection does not bypass the fault reaction
  pocr_ov_ctrl u_ov (
    .clk_in         (clk_in),
    .rst_in         (rst_in),
    .react_in       (reg_val[IDX_OV_REACT][7:0]),
    .ov_fault_in    (ov_fault_in),
    .ctrl_pin_in    (ctrl_pin_in),
    .op_on_in       (op_on_in),
    .bias_ok_in     (bias_ok_in),
    .other_fault_in (other_fault_in),
    .output_en_out  (output_en_out),
    .ov_hold_out    (ov_hold_out)
  );

  // ****************************************
  // checks
  // ****************************************
  property p_trim_factory;
    @(posedge clk_in)
    rst_in |=> (cfg_out.trim == $past(factory_trim_in));
  endproperty
  a_trim_factory: assert property (p_trim_factory)
    else $error("trim did not load the factory value");

  property p_role_reserved;
    @(posedge clk_in) disable iff (rst_in)
    (cfg_out.role[15:12] == 4'h0) && (cfg_out.role[3:0] == 4'h0);
  endproperty
  a_role_reserved: assert property (p_role_reserved)
    else $error("reserved role bits set");

  property p_role_default;
    @(posedge clk_in)
    rst_in ##1 !rst_in |-> (cfg_out.role[11:8] == 4'h1) && (cfg_out.role[7:4] == 4'h0);
  endproperty
  a_role_default: assert property (p_role_default)
    else $error("role default wrong");

  property p_ratio_set;
    @(posedge clk_in) disable iff (rst_in)
    (cmd_valid_in && cmd_in.write && hit[IDX_RATIO] && !data_ok)
      |=> $stable(cfg_out.ratio) && rsp_out.err;
  endproperty
  a_ratio_set: assert property (p_ratio_set)
    else $error("unsupported loop ratio accepted");

  property p_ratio_default;
    @(posedge clk_in)
    rst_in ##1 !rst_in |-> (cfg_out.ratio == RATIO_ONE);
  endproperty
  a_ratio_default: assert property (p_ratio_default)
    else $error("loop ratio default is not one");

  property p_mode_read;
    @(posedge clk_in) disable iff (rst_in)
    (cmd_valid_in && !cmd_in.write && cmd_in.code == MODE_CODE)
      |=> rsp_out.ack && !rsp_out.err && (rsp_out.rdata == MODE_VALUE);
  endproperty
  a_mode_read: assert property (p_mode_read)
    else $error("mode register read wrong");

  property p_margin_fault;
    @(posedge clk_in) disable iff (rst_in)
    (margin_sel_in && output_en_out && ov_fault_in && cfg_out.ov_react == OV_REACT_HOLD &&
     ctrl_pin_in && op_on_in && bias_ok_in && !other_fault_in)
      |=> ov_hold_out;
  endproperty
  a_margin_fault: assert property (p_margin_fault)
    else $error("margin fault not handled by reaction");

  property p_write_read;
    @(posedge clk_in) disable iff (rst_in)
    (cmd_valid_in && cmd_in.write && hit[IDX_CEIL])
      ##1 (cmd_valid_in && !cmd_in.write && hit[IDX_CEIL])
      |=> (rsp_out.rdata == $past(cmd_in.wdata, 2));
  endproperty
  a_write_read: assert property (p_write_read)
    else $error("read did not return last written value");

  // ****************************************
  // command port checks
  // ****************************************
  property p_ack_follows;
    @(posedge clk_in) disable iff (rst_in)
    cmd_valid_in |=> rsp_out.ack;
  endproperty
  a_ack_follows: assert property (p_ack_follows)
    else $error("command not answered");

  property p_ack_pulse;
    @(posedge clk_in) disable iff (rst_in)
    !cmd_valid_in |=> !rsp_out.ack && !rsp_out.err;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("answer without a command");

  property p_unknown_code;
    @(posedge clk_in) disable iff (rst_in)
    (cmd_valid_in && !any_hit && cmd_in.code != MODE_CODE) |=> rsp_out.err;
  endproperty
  a_unknown_code: assert property (p_unknown_code)
    else $error("unknown code not refused");

  property p_mode_write;
    @(posedge clk_in) disable iff (rst_in)
    (cmd_valid_in && cmd_in.write && cmd_in.code == MODE_CODE) |=> rsp_out.err;
  endproperty
  a_mode_write: assert property (p_mode_write)
    else $error("write to mode register not refused");

  property p_trim_refused;
    @(posedge clk_in) disable iff (rst_in)
    (cmd_valid_in && cmd_in.write && hit[IDX_TRIM] && !data_ok)
      |=> $stable(cfg_out.trim) && rsp_out.err;
  endproperty
  a_trim_refused: assert property (p_trim_refused)
    else $error("out of range trim accepted");

  property p_trim_write;
    @(posedge clk_in) disable iff (rst_in)
    (cmd_valid_in && cmd_in.write && hit[IDX_TRIM] && data_ok)
      |=> (cfg_out.trim == $past(cmd_in.wdata));
  endproperty
  a_trim_write: assert property (p_trim_write)
    else $error("legal trim not stored");

  property p_ratio_legal;
    @(posedge clk_in) disable iff (rst_in)
    (cfg_out.ratio == RATIO_ONE) || (cfg_out.ratio == RATIO_HALF) ||
    (cfg_out.ratio == RATIO_QUARTER) || (cfg_out.ratio == RATIO_EIGHTH);
  endproperty
  a_ratio_legal: assert property (p_ratio_legal)
    else $error("loop ratio outside the accepted set");

  property p_role_write;
    @(posedge clk_in) disable iff (rst_in)
    (cmd_valid_in && cmd_in.write && hit[IDX_ROLE])
      |=> (cfg_out.role == ($past(cmd_in.wdata) & REG_MASK[IDX_ROLE]));
  endproperty
  a_role_write: assert property (p_role_write)
    else $error("role write stored wrong bits");

  property p_react_refused;
    @(posedge clk_in) disable iff (rst_in)
    (cmd_valid_in && cmd_in.write && hit[IDX_OV_REACT] && !data_ok)
      |=> $stable(cfg_out.ov_react) && rsp_out.err;
  endproperty
  a_react_refused: assert property (p_react_refused)
    else $error("unsupported reaction accepted");

  property p_ceil_write;
    @(posedge clk_in) disable iff (rst_in)
    (cmd_valid_in && cmd_in.write && hit[IDX_CEIL])
      |=> (cfg_out.ceil == $past(cmd_in.wdata));
  endproperty
  a_ceil_write: assert property (p_ceil_write)
    else $error("ceiling write not stored");

endmodule // pocr_regs

//--- tb/pocr_host.sv
`timescale 1ns/1ns
// ****************************************
// bus host model driving the command port
// ****************************************
module pocr_host
  import pocr_pkg::*;
(
  input  wire logic      clk_in,
  input  wire pocr_rsp_s rsp_in,
  output logic           cmd_valid_out,
  output pocr_cmd_s      cmd_out,
  output logic           op_on_out
);
  // idle values at time zero
  initial begin
    cmd_valid_out = 1'b0;
    cmd_out = '0;
    op_on_out = 1'b0;
  end

  // one command, answer caught within a few cycles
  task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] wd,
                      output pocr_rsp_s rsp);
    int n;
    n = 0;
    @(negedge clk_in);
    cmd_valid_out = 1'b1;
    cmd_out = '{wr, code, wd};
    @(negedge clk_in);
    cmd_valid_out = 1'b0;
    cmd_out = ~cmd_out; // released bus shows no stale value
    while (rsp_in.ack !== 1'b1 && n < 3) begin
      @(negedge clk_in);
      n++;
    end
    rsp = rsp_in;
  endtask

  // write then read of one code on back-to-back cycles
  task automatic wr_rd(input logic [7:0] code, input logic [15:0] wd,
                       output pocr_rsp_s rsp);
    @(negedge clk_in);
    cmd_valid_out = 1'b1;
    cmd_out = '{1'b1, code, wd};
    @(negedge clk_in);
    cmd_out = '{1'b0, code, 16'h0000};
    @(negedge clk_in);
    cmd_valid_out = 1'b0;
    cmd_out = ~cmd_out; // released bus shows no stale value
    rsp = rsp_in;
  endtask

  // on/off bit of the operation command, called at a falling edge
  task automatic set_op(input logic on);
    op_on_out = on;
  endtask
endmodule // pocr_host

//--- tb/pocr_regs_tb.sv
`timescale 1ns/1ns
module pocr_regs_tb;
  import pocr_pkg::*;
  localparam logic [15:0] FACT = 16'h0031;
  logic      clk_in = 1'b0;
  logic      rst_in = 1'b1;
  logic      ov_fault = 1'b0;
  logic      margin_sel = 1'b0;
  logic      ctrl_pin = 1'b0;
  logic      bias_ok = 1'b1;
  logic      other_fault = 1'b0;
  logic      cmd_valid;
  logic      op_on;
  logic      en;
  logic      hold;
  pocr_cmd_s cmd;
  pocr_rsp_s rsp;
  pocr_cfg_s cfg;
  int        fail_count = 0;
  int        n_checks = 0;
  int        cycles = 0;

  // 50 MHz clock
  always #10 clk_in = ~clk_in;

  pocr_host pocr_host_i (.clk_in(clk_in), .rsp_in(rsp), .cmd_valid_out(cmd_valid),
    .cmd_out(cmd), .op_on_out(op_on));

  pocr_regs pocr_regs_i (.clk_in(clk_in), .rst_in(rst_in), .cmd_valid_in(cmd_valid),
    .cmd_in(cmd), .factory_trim_in(FACT), .ov_fault_in(ov_fault),
    .margin_sel_in(margin_sel), .ctrl_pin_in(ctrl_pin), .op_on_in(op_on),
    .bias_ok_in(bias_ok), .other_fault_in(other_fault), .rsp_out(rsp), .cfg_out(cfg),
    .output_en_out(en), .ov_hold_out(hold));

  // ****************************************
  // compare and report
  // ****************************************
  task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_flag(input string what, input logic exp, input logic got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // command with answer checks
  task automatic acc(input logic wr, input logic [7:0] code, input logic [15:0] wd,
                     input logic err, input logic [15:0] rd);
    pocr_rsp_s r;
    pocr_host_i.xfer(wr, code, wd, r);
    chk_flag("ack", 1'b1, r.ack);
    chk_flag("err", err, r.err);
    if (!wr && !err) chk_word("rdata", rd, r.rdata);
  endtask

  // one cycle, then output state
  task automatic st(input logic e, input logic h);
    @(negedge clk_in);
    chk_flag("output enable", e, en);
    chk_flag("ov hold", h, hold);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_defaults();
    for (int i = 0; i < NREG; i++) begin
      acc(1'b0, REG_CODE[i], 16'h0000, 1'b0, (i == IDX_TRIM) ? FACT : REG_RST[i]);
    end
    chk_word("trim", FACT, cfg.trim);
    chk_word("role", 16'h0100, cfg.role);
    chk_word("ratio", 16'he808, cfg.ratio);
    acc(1'b0, MODE_CODE, 16'h0000, 1'b0, 16'h0017);
    acc(1'b1, MODE_CODE, 16'h0015, 1'b1, 16'h0000);
    acc(1'b0, 8'h23, 16'h0000, 1'b1, 16'h0000);
    $display("test defaults done");
  endtask

  task automatic t_access();
    logic [15:0] rt [4];
    pocr_rsp_s   r;
    rt = '{16'he801, 16'he802, 16'he804, 16'he808};
    for (int i = 0; i < 4; i++) begin
      acc(1'b1, 8'h29, rt[i], 1'b0, 16'h0000);
      acc(1'b0, 8'h29, 16'h0000, 1'b0, rt[i]);
    end
    acc(1'b1, 8'h29, 16'he803, 1'b1, 16'h0000);
    acc(1'b0, 8'h29, 16'h0000, 1'b0, 16'he808);
    acc(1'b1, 8'h22, 16'hfc00, 1'b0, 16'h0000);
    acc(1'b1, 8'h22, 16'h0401, 1'b1, 16'h0000);
    acc(1'b0, 8'h22, 16'h0000, 1'b0, 16'hfc00);
    acc(1'b1, 8'h22, 16'h0400, 1'b0, 16'h0000);
    chk_word("trim", 16'h0400, cfg.trim);
    acc(1'b1, 8'h37, 16'hffff, 1'b0, 16'h0000);
    acc(1'b0, 8'h37, 16'h0000, 1'b0, 16'h0ff0);
    acc(1'b1, 8'h37, 16'h0110, 1'b0, 16'h0000);
    acc(1'b0, 8'h37, 16'h0000, 1'b0, 16'h0110);
    acc(1'b1, 8'h24, 16'h0abc, 1'b0, 16'h0000);
    acc(1'b0, 8'h24, 16'h0000, 1'b0, 16'h0abc);
    chk_word("ceil", 16'h0abc, cfg.ceil);
    pocr_host_i.wr_rd(8'h24, 16'h0def, r);
    chk_flag("ack", 1'b1, r.ack);
    chk_flag("err", 1'b0, r.err);
    chk_word("ceil readback", 16'h0def, r.rdata);
    chk_word("ceil", 16'h0def, cfg.ceil);
    acc(1'b1, 8'h41, 16'h0012, 1'b1, 16'h0000);
    $display("test access done");
  endtask

  task automatic t_ov();
    ctrl_pin = 1'b1;
    pocr_host_i.set_op(1'b1);
    margin_sel = 1'b1;
    st(1'b1, 1'b0);
    ov_fault = 1'b1;
    st(1'b0, 1'b1);
    st(1'b0, 1'b1);
    for (int i = 0; i < 3; i++) begin
      ov_fault = 1'b0;
      st(1'b1, 1'b0);
      ov_fault = 1'b1;
      st(1'b0, 1'b1);
    end
    ctrl_pin = 1'b0;
    st(1'b0, 1'b0);
    ov_fault = 1'b0;
    st(1'b0, 1'b0);
    ctrl_pin = 1'b1;
    st(1'b1, 1'b0);
    ov_fault = 1'b1;
    st(1'b0, 1'b1);
    pocr_host_i.set_op(1'b0);
    st(1'b0, 1'b0);
    pocr_host_i.set_op(1'b1);
    ov_fault = 1'b0;
    st(1'b1, 1'b0);
    ov_fault = 1'b1;
    other_fault = 1'b1;
    st(1'b0, 1'b0);
    other_fault = 1'b0;
    bias_ok = 1'b0;
    ov_fault = 1'b0;
    st(1'b0, 1'b0);
    bias_ok = 1'b1;
    st(1'b1, 1'b0);
    acc(1'b1, 8'h41, 16'h0000, 1'b0, 16'h0000);
    chk_word("reaction", 16'h0000, {8'h00, cfg.ov_react});
    ov_fault = 1'b1;
    st(1'b1, 1'b0);
    ov_fault = 1'b0;
    acc(1'b1, 8'h41, 16'h00c0, 1'b0, 16'h0000);
    ov_fault = 1'b1;
    st(1'b0, 1'b0);
    ov_fault = 1'b0;
    st(1'b0, 1'b0);
    ctrl_pin = 1'b0;
    st(1'b0, 1'b0);
    ctrl_pin = 1'b1;
    st(1'b1, 1'b0);
    acc(1'b1, 8'h41, 16'h00f8, 1'b0, 16'h0000);
    chk_word("reaction", 16'h00f8, {8'h00, cfg.ov_react});
    $display("test fault reaction done");
  endtask

  // cycle ceiling against a hang
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      complete_run();
    end
  end

  // main sequence
  initial begin
    repeat (6) @(negedge clk_in);
    rst_in = 1'b0;
    t_defaults();
    t_access();
    t_ov();
    complete_run();
  end
endmodule // pocr_regs_tb
